//--- logic/sac_pkg.sv
`default_nettype none
package sac_pkg;
   // ------------------------------------------------------------
   // Resolution and codes
   // ------------------------------------------------------------
   localparam int RES_BITS = 18;
   typedef logic [RES_BITS-1:0] sac_code_t;
   localparam sac_code_t CODE_ZERO = 18'h00000;  // Zero input
   localparam sac_code_t CODE_ONES = 18'h3ffff;  // Full scale minus 1 LSB
   localparam sac_code_t CODE_MID  = 18'h20000;  // Midscale
   localparam logic [4:0] MSB_INDEX = 5'h11;

   // ------------------------------------------------------------
   // Timing
   // ------------------------------------------------------------
   localparam int CLK_PERIOD_NS = 10;
   localparam int CONV_TIME_NS  = 1400;
   // Longest time, rounded down
   localparam int CONV_CYCLES   = CONV_TIME_NS / CLK_PERIOD_NS;
   localparam int BIT_CYCLES    = CONV_CYCLES / RES_BITS;
   localparam logic [2:0] BIT_LAST = 3'(BIT_CYCLES - 1);

   // ------------------------------------------------------------
   // Synchroniser lanes
   // ------------------------------------------------------------
   localparam int IN_CONV  = 0;
   localparam int IN_CS    = 1;
   localparam int IN_RD    = 2;
   localparam int IN_UPPER = 3;
   localparam int IN_WIDTH = 4;
   localparam int IN_CMP   = 5;
   localparam int IN_COUNT = 6;

   // ------------------------------------------------------------
   // Control states
   // ------------------------------------------------------------
   typedef enum logic [2:0] {
      ST_IDLE   = 3'h1,
      ST_SAMPLE = 3'h2,
      ST_CONV   = 3'h4
   } sac_state_t;
endpackage : sac_pkg
`default_nettype wire

//--- logic/sac_sar_if.sv
`timescale 1ns/100ps
`default_nettype none
interface sac_sar_if
   import sac_pkg::*;
   (input wire logic clk);
   logic      start;
   logic      abort;
   logic      cmp_high;
   logic      done;
   logic      busy;
   sac_code_t result;
   sac_code_t trial;

   modport ctrl (output start, abort, cmp_high,
                 input  done, busy, result, trial);
   modport eng  (input  start, abort, cmp_high,
                 output done, busy, result, trial);
endinterface : sac_sar_if
`default_nettype wire

//--- logic/sac_sar_engine.sv
`timescale 1ns/100ps
`default_nettype none
module sac_sar_engine
   import sac_pkg::*;
(
   // Clock and reset
   input wire logic clk,
   input wire logic nrst,
   // Control side
   sac_sar_if.eng   sar
);
   typedef struct packed {
      logic       busy;
      logic       done;
      logic [4:0] idx;
      logic [2:0] step;
      sac_code_t  code;
      sac_code_t  trial;
   } sac_eng_t;

   sac_eng_t s;
   sac_eng_t next_s;
   sac_code_t keep;

   // ------------------------------------------------------------
   // Bit-by-bit approximation, paced by the internal clock
   // ------------------------------------------------------------
   always_comb begin
      next_s      = s;
      next_s.done = 1'b0;
      keep        = sar.cmp_high ? s.trial : s.code;
      if (sar.abort) begin
         next_s.busy  = 1'b0;
         next_s.code  = CODE_ZERO;
         next_s.trial = CODE_ZERO;
      end else if (sar.start) begin
         next_s.busy  = 1'b1;
         next_s.idx   = MSB_INDEX;
         next_s.step  = 3'h0;
         next_s.code  = CODE_ZERO;
         next_s.trial = sac_code_t'(1) << MSB_INDEX;
      end else if (s.busy) begin
         if (s.step == BIT_LAST) begin
            next_s.step = 3'h0;
            next_s.code = keep;
            if (s.idx == 5'h00) begin
               next_s.busy  = 1'b0;
               next_s.done  = 1'b1;
               next_s.trial = keep;
            end else begin
               next_s.idx   = s.idx - 5'h01;
               next_s.trial = keep | (sac_code_t'(1) << (s.idx - 5'h01));
            end
         end else begin
            next_s.step = s.step + 3'h1;
         end
      end
   end

   // State register
   always_ff @(posedge clk or negedge nrst) begin
      if (!nrst) begin
         s <= '0;
      end else begin
         s <= next_s;
      end
   end

   assign sar.busy   = s.busy;
   assign sar.done   = s.done;
   assign sar.result = s.code;
   assign sar.trial  = s.trial;
endmodule : sac_sar_engine
`default_nettype wire

//--- logic/sac_conv_ctrl.sv
`timescale 1ns/100ps
`default_nettype none
module sac_conv_ctrl
   import sac_pkg::*;
(
   // Clock and reset
   input  wire logic            clk,
   input  wire logic            nrst,
   // Host control pins
   input  wire logic            conversion_start_n,
   input  wire logic            chip_select_n,
   input  wire logic            read_n,
   input  wire logic            upper_lane_select,
   input  wire logic            word_width_select,
   // Analog front end
   input  wire logic            comparator_high,
   output var  logic            sampling,
   output var  logic [RES_BITS-1:0] dac_code,
   // Host status and data pins
   output var  logic            busy,
   output var  logic [RES_BITS-1:0] result_data_pins,
   output var  logic            result_data_oe_n
);
   typedef struct packed {
      logic [IN_COUNT-1:0] s1;
      logic [IN_COUNT-1:0] s2;
      logic [IN_COUNT-1:0] prev;
      sac_state_t          state;
      logic                busy;
      logic                sampling;
      sac_code_t           dac;
      sac_code_t           latch;
      sac_code_t           data;
      logic                oe_n;
   } sac_ctrl_t;

   sac_ctrl_t s;
   sac_ctrl_t next_s;
   logic      conv_fall;
   logic      cs_fall;
   logic      cs_low;
   logic      rd_low;

   sac_sar_if sar (.clk(clk));

   // ------------------------------------------------------------
   // Approximation engine
   // ------------------------------------------------------------
   sac_sar_engine u_engine (
      .clk  (clk),
      .nrst (nrst),
      .sar  (sar.eng)
   );

   // Pin edges seen after two-stage synchronisation
   assign conv_fall = s.prev[IN_CONV] & ~s.s2[IN_CONV];
   assign cs_fall   = s.prev[IN_CS] & ~s.s2[IN_CS];
   assign cs_low    = ~s.s2[IN_CS];
   assign rd_low    = ~s.s2[IN_RD];

   // Lane mapping of the held result
   function automatic sac_code_t lane_map(input sac_code_t r,
                                          input logic up,
                                          input logic wide);
      sac_code_t m;
      m = CODE_ONES;
      unique case ({up, wide})
         2'b00: m = r;
         2'b01: m[3:2] = r[1:0];
         2'b10: m[17:10] = r[9:2];
         2'b11: m[11:10] = r[1:0];
      endcase
      return m;
   endfunction : lane_map

   // ------------------------------------------------------------
   // Sequencing of sample, hold and conversion
   // ------------------------------------------------------------
   always_comb begin
      next_s      = s;
      sar.start   = 1'b0;
      sar.abort   = 1'b0;
      sar.cmp_high = s.s2[IN_CMP];
      next_s.s1   = {comparator_high, word_width_select, upper_lane_select,
                     read_n, chip_select_n, conversion_start_n};
      next_s.s2   = s.s1;
      next_s.prev = s.s2;
      unique case (s.state)
         ST_IDLE: begin
            if (conv_fall && cs_low) begin
               next_s.state = ST_CONV;
               sar.start    = 1'b1;
            end else if (cs_fall) begin
               next_s.state = ST_SAMPLE;
            end
         end
         ST_SAMPLE: begin
            if (conv_fall && cs_low) begin
               next_s.state = ST_CONV;
               sar.start    = 1'b1;
            end
         end
         ST_CONV: begin
            if ((conv_fall && cs_low) || cs_fall) begin
               sar.abort    = 1'b1;
               next_s.latch = CODE_ZERO;
               next_s.state = ST_SAMPLE;
            end else if (sar.done) begin
               next_s.latch = sar.result;
               next_s.state = cs_low ? ST_SAMPLE : ST_IDLE;
            end
         end
         default: next_s.state = ST_IDLE;
      endcase
      next_s.busy     = (next_s.state == ST_CONV);
      next_s.sampling = (next_s.state == ST_SAMPLE);
      next_s.dac      = sar.trial;
      next_s.data     = lane_map(s.latch, s.s2[IN_UPPER],
                                 s.s2[IN_WIDTH]);
      next_s.oe_n     = ~(cs_low & rd_low);
   end

   // State register
   always_ff @(posedge clk or negedge nrst) begin
      if (!nrst) begin
         s       <= '0;
         s.s1    <= {IN_COUNT{1'b1}};
         s.s2    <= {IN_COUNT{1'b1}};
         s.prev  <= {IN_COUNT{1'b1}};
         s.state <= ST_IDLE;
         s.oe_n  <= 1'b1;
      end else begin
         s <= next_s;
      end
   end

   // Outputs straight from the state register
   assign busy             = s.busy;
   assign sampling         = s.sampling;
   assign dac_code         = s.dac;
   assign result_data_pins = s.data;
   assign result_data_oe_n = s.oe_n;

   // ------------------------------------------------------------
   // Checks
   // ------------------------------------------------------------
   localparam int CONV_LIMIT = CONV_CYCLES;
   logic [7:0] busy_cnt;

   // Length of the current busy phase
   always_ff @(posedge clk or negedge nrst) begin
      if (!nrst) begin
         busy_cnt <= 8'h00;
      end else begin
         busy_cnt <= s.busy ? busy_cnt + 8'h01 : 8'h00;
      end
   end

   default clocking cb @(posedge clk); endclocking
   default disable iff (!nrst);

   sequence start_seen;
      conv_fall && cs_low && !s.busy;
   endsequence
   sequence conv_done_sel;
      s.busy && sar.done && !conv_fall && !cs_fall && cs_low;
   endsequence
   sequence abort_seen;
      s.busy && (cs_fall || (conv_fall && cs_low));
   endsequence

   busy_rise_a: assert property (start_seen |=> busy && !sampling)
      else $error("busy did not rise after start");
   conv_time_a: assert property (busy_cnt <= CONV_LIMIT)
      else $error("conversion longer than allowed");
   busy_fall_a: assert property (s.busy && sar.done |=> !busy)
      else $error("busy stayed high after conversion");
   hold_phase_a: assert property (start_seen |=> !sampling[*8])
      else $error("sampling during hold");
   sample_after_a: assert property (conv_done_sel |=> sampling)
      else $error("no sampling after busy fell");
   idle_sample_a: assert property
      (s.state == ST_IDLE && cs_fall && !conv_fall |=> sampling)
      else $error("no sampling at select fall");
   bus_drive_a: assert property
      (result_data_oe_n == !$past(cs_low && rd_low))
      else $error("bus enable does not follow selects");
   abort_clear_a: assert property
      (abort_seen |=> !busy && sampling && s.latch == CODE_ZERO)
      else $error("abort did not reset conversion");
   full_word_a: assert property
      (!s.s2[IN_UPPER] && !s.s2[IN_WIDTH]
       |=> result_data_pins == $past(s.latch))
      else $error("full word not presented");
   upper_low_a: assert property
      (s.s2[IN_UPPER] && s.s2[IN_WIDTH] |=>
       result_data_pins[11:10] == $past(s.latch[1:0]) &&
       result_data_pins[17:12] == 6'h3f)
      else $error("upper lane low bits misplaced");
endmodule : sac_conv_ctrl
`default_nettype wire

//--- verification/sac_analog_model.sv
`timescale 1ns/100ps
`default_nettype none
module sac_analog_model
   import sac_pkg::*;
(
   // Clock
   input  wire logic      clk,
   // Input level and converter taps
   input  wire sac_code_t level,
   input  wire logic      busy,
   input  wire sac_code_t dac_code,
   // Comparator
   output var  logic      comparator_high
);
   sac_code_t held;

   // Track while idle, freeze once the conversion runs
   always_ff @(posedge clk) begin
      if (!busy) begin
         held <= level;
      end
   end

   // High when the held level is at or above the trial code
   assign comparator_high = (held >= dac_code);
endmodule : sac_analog_model
`default_nettype wire

//--- verification/tb.sv
`timescale 1ns/100ps
`default_nettype none
module tb
   import sac_pkg::*;
;
   logic        clk;
   logic        nrst;
   logic        conv_n;
   logic        cs_n;
   logic        rd_n;
   logic        upper;
   logic        width;
   logic        cmp;
   logic        sampling;
   sac_code_t   dac_code;
   logic        busy;
   sac_code_t   data;
   logic        oe_n;
   sac_code_t   level;
   int          n_fail;
   int          check_count;
   logic [31:0] seed;
   sac_code_t   exp_q[$];
   sac_code_t   edge_c[4] = '{CODE_ZERO, CODE_ONES, CODE_MID, 18'h1ffff};

   sac_conv_ctrl uut (
      .clk(clk), .nrst(nrst), .conversion_start_n(conv_n),
      .chip_select_n(cs_n), .read_n(rd_n), .upper_lane_select(upper),
      .word_width_select(width), .comparator_high(cmp),
      .sampling(sampling), .dac_code(dac_code), .busy(busy),
      .result_data_pins(data), .result_data_oe_n(oe_n));

   sac_analog_model afe (
      .clk(clk), .level(level), .busy(busy), .dac_code(dac_code),
      .comparator_high(cmp));

   // --------------------------------------------------------
   // Helpers
   // --------------------------------------------------------
   function automatic logic [31:0] xorshift(input logic [31:0] s);
      logic [31:0] x;
      x = s ^ (s << 13);
      x = x ^ (x >> 17);
      return x ^ (x << 5);
   endfunction : xorshift

   task automatic tick(input int n);
      repeat (n) @(posedge clk);
      #1;
   endtask : tick

   task automatic final_report;
      $display("checks %0d mismatches %0d", check_count, n_fail);
      if (n_fail == 0 && check_count > 0) begin
         $display("DONE - PASS");
      end else begin
         $display("DONE - FAIL");
      end
      $finish;
   endtask : final_report

   task automatic chk_bit(input logic got, input logic exp, input string s);
      check_count++;
      if (got !== exp) begin
         n_fail++;
         $display("BAD %0t %s got %b", $time, s, got);
      end
   endtask : chk_bit

   task automatic chk_data(input sac_code_t got, input sac_code_t exp);
      check_count++;
      if (got !== exp) begin
         n_fail++;
         $display("BAD %0t data %h exp %h", $time, got, exp);
      end
   endtask : chk_data

   task automatic wait_busy(input logic v, input int max, output int n);
      n = 0;
      while (busy !== v) begin
         if (n >= max) begin
            n_fail++;
            $display("BAD %0t busy wait timed out", $time);
            final_report();
         end
         tick(1);
         n++;
      end
   endtask : wait_busy

   // One conversion, optionally deselecting during it
   task automatic convert(input sac_code_t code, input logic rel);
      int n;
      int m;
      level = code;
      tick(1);
      conv_n = 1'b0;
      wait_busy(1'b1, 6, n);
      chk_bit(sampling, 1'b0, "hold");
      tick(1);
      chk_data(dac_code, CODE_MID);
      conv_n = 1'b1;
      cs_n = rel;
      wait_busy(1'b0, CONV_CYCLES - n - 1, m);
      chk_bit(sampling, ~cs_n, "sample");
      exp_q.push_back(code);
   endtask : convert

   // Read all four lane mappings of the oldest result
   task automatic read_all;
      sac_code_t c;
      sac_code_t e;
      c = exp_q.pop_front();
      rd_n = 1'b0;
      for (int k = 0; k < 4; k++) begin
         {upper, width} = 2'(k);
         tick(4);
         chk_bit(oe_n, 1'b0, "oe on");
         e = '1;
         case (k)
            0: e = c;
            1: e[3:2] = c[1:0];
            2: e[17:10] = c[9:2];
            default: e[11:10] = c[1:0];
         endcase
         chk_data(data, e);
      end
      rd_n = 1'b1;
      {upper, width} = 2'b00;
      tick(4);
      chk_bit(oe_n, 1'b1, "oe off");
      tick(13);
   endtask : read_all

   // Abort mid-conversion by start or by select
   task automatic abort_run(input logic by_cs);
      int n;
      level = CODE_ONES;
      conv_n = 1'b0;
      wait_busy(1'b1, 6, n);
      tick(1);
      conv_n = 1'b1;
      cs_n = by_cs;
      tick(50);
      cs_n = 1'b0;
      conv_n = by_cs;
      wait_busy(1'b0, 6, n);
      chk_bit(sampling, 1'b1, "abort sample");
      tick(1);
      conv_n = 1'b1;
      exp_q.push_back(CODE_ZERO);
      read_all();
   endtask : abort_run

   // --------------------------------------------------------
   // Clock and main sequence
   // --------------------------------------------------------
   initial begin
      clk = 1'b0;
      forever #5 clk = ~clk;
   end

   initial begin
      {nrst, conv_n, cs_n, rd_n, upper, width} = 6'b011100;
      level = CODE_MID;
      n_fail = 0;
      check_count = 0;
      seed = 32'h336c93da;
      tick(12);
      nrst = 1'b1;
      chk_bit(busy, 1'b0, "rst busy");
      chk_bit(oe_n, 1'b1, "rst oe");
      cs_n = 1'b0;
      repeat (3) begin
         rd_n = 1'b0;
         tick(4);
         rd_n = 1'b1;
         tick(4);
      end
      tick(13);
      for (int i = 0; i < 8; i++) begin
         seed = xorshift(seed);
         convert((i < 4) ? edge_c[i] : seed[17:0], 1'b0);
         read_all();
      end
      // Start with select high is ignored, bus stays off
      cs_n = 1'b1;
      rd_n = 1'b0;
      conv_n = 1'b0;
      tick(5);
      conv_n = 1'b1;
      tick(6);
      chk_bit(busy, 1'b0, "no start");
      chk_bit(oe_n, 1'b1, "cs high oe");
      rd_n = 1'b1;
      cs_n = 1'b0;
      tick(13);
      // Deselect during conversion, sampling waits for select
      convert(CODE_MID, 1'b1);
      cs_n = 1'b0;
      tick(5);
      chk_bit(sampling, 1'b1, "cs sample");
      read_all();
      abort_run(1'b0);
      abort_run(1'b1);
      final_report();
   end
endmodule : tb
`default_nettype wire
